// ==== common/rapg_defines.svh ====
`ifndef RAPG_DEFINES_SVH
`define RAPG_DEFINES_SVH

// ----------------------------------------
// register byte offsets and page numbers
// ----------------------------------------
`define RAPG_OFF_CMD     8'h00
`define RAPG_OFF_ARG     8'h04
`define RAPG_OFF_CFG     8'h08
`define RAPG_OFF_STAT    8'h0c
`define RAPG_OFF_SKEY    8'h10
`define RAPG_OFF_CNT     8'h14
`define RAPG_PAGE_DIN    4'h2
`define RAPG_PAGE_RES    4'h3

// ----------------------------------------
// field positions and masks
// ----------------------------------------
`define RAPG_CMD_MODE    4
`define RAPG_CMD_TYPE2   6
`define RAPG_CMD_SEL     7
`define RAPG_ARG_PLEN    8
`define RAPG_ARG_MASK    32'h0000_1fff
`define RAPG_CFG_RDC     2
`define RAPG_CFG_UPC     4
`define RAPG_CFG_SEAL    6
`define RAPG_CFG_MASK    32'h0000_007f

// ----------------------------------------
// counts and responses
// ----------------------------------------
`define RAPG_CODE_TRIES  2'h3
`define RAPG_UNBLK_TRIES 4'ha
`define RAPG_PAT_MAX     5'h10
`define RAPG_RESP_OKAY   2'h0
`define RAPG_RESP_SLVERR 2'h2

`endif

// ==== common/rapg_pkg.sv ====
package rapg_pkg;

  typedef enum logic [3:0] {
    OP_SELECT = 4'h0, OP_READ = 4'h1, OP_UPDATE = 4'h2, OP_SEEK = 4'h3,
    OP_READ_KEY = 4'h4, OP_VERIFY = 4'h5, OP_CHANGE = 4'h6, OP_DISABLE = 4'h7,
    OP_ENABLE = 4'h8, OP_UNBLOCK = 4'h9, OP_END_SESSION = 4'ha
  } rapg_op_type;

  typedef enum logic [3:0] {
    S_OK = 4'h0, S_NO_DATA = 4'h1, S_ACCESS = 4'h2, S_BAD_MODE = 4'h3,
    S_NOT_FOUND = 4'h4, S_WRONG = 4'h5, S_BLOCKED = 4'h6, S_STATE = 4'h7,
    S_BAD_FILE = 4'h8, S_BAD_ARG = 4'h9, S_BAD_OP = 4'ha
  } rapg_stat_type;

  typedef enum logic [1:0] {K_LINEAR = 2'h0, K_CYCLIC = 2'h1, K_KEY = 2'h2} rapg_kind_type;

  typedef enum logic [1:0] {AC_ALW = 2'h0, AC_CODE1 = 2'h1, AC_CODE2 = 2'h2, AC_NEVER = 2'h3} rapg_ac_type;

  typedef enum logic {FSM_IDLE, FSM_EXEC} rapg_fsm_type;

endpackage

// ==== src/rapg_top.sv ====
// Notes on behaviour
// - previous read steps back; undefined reads last
// - linear previous at first: no move, no data
// - cyclic previous at first wraps to last
// - key read uses absolute record number only
// - sealing service set: key record sealed first
// - update needs access; failure keeps pointer
// - cyclic files accept only previous update
// - current and absolute update keep pointer
// - next update steps forward; last linear refused
// - previous linear update steps back; first refused
// - cyclic update overwrites oldest, becomes record one
// - search linear only, readable, type two numbers
// - pattern length one to sixteen bytes
// - four search modes; undefined pointer start ends
// - hit moves pointer; miss keeps it
// - verify refused when code disabled or blocked
// - good resets to three; three failures block
// - protected files need verified or disabled code
// - change needs good old value, installs new
// - disable first code only, good value disables
// - wrong disable value decrements, stays enabled
// - enable first code only, mirrors disable
// - good unblock installs code, counters ten, three
`timescale 1ns/1ps
`include "rapg_defines.svh"

module rapg_top
  import rapg_pkg::*;
#(
  parameter int          NREC        = 8,
  parameter logic [31:0] CODE1_INIT  = 32'h0000_1111,
  parameter logic [31:0] CODE2_INIT  = 32'h0000_2222,
  parameter logic [31:0] UNBLK1_INIT = 32'h0000_3333,
  parameter logic [31:0] UNBLK2_INIT = 32'h0000_4444
) (
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [7:0]  awaddr_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  output logic [1:0]       bresp_o,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  input  wire logic [7:0]  araddr_i,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o
);

  localparam int         IW   = $clog2(NREC);
  localparam logic [7:0] LAST = 8'(NREC);

  typedef struct packed {
    rapg_fsm_type            fsm;
    rapg_op_type             op;
    logic [1:0]              mode;
    logic                    type2;
    logic                    sel;
    logic [31:0]             arg;
    logic [31:0]             cfg;
    logic [31:0]             skey;
    logic [3:0][31:0]        din;
    logic [3:0][31:0]        res;
    logic [NREC-1:0][127:0]  mem;
    logic [7:0]              ptr;
    logic                    pdef;
    logic [IW-1:0]           head;
    rapg_stat_type           status;
    logic [7:0]              found;
    logic [1:0][31:0]        code;
    logic [1:0][31:0]        ucode;
    logic [1:0][1:0]         cnt;
    logic [1:0][3:0]         ucnt;
    logic                    dis1;
    logic [1:0]              ver;
    logic                    awrdy;
    logic                    wrdy;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic [7:0]              awaddr;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    logic                    arrdy;
    logic                    rvalid;
    logic [1:0]              rresp;
    logic [31:0]             rdata;
  } rapg_state_type;

  rapg_state_type q;
  rapg_state_type d;
  rapg_kind_type  kind;
  rapg_ac_type    rdc;
  rapg_ac_type    upc;
  logic [4:0]     plen;
  logic           rec_file;
  logic [8:0]     sr;
  logic [7:0]     sstart;
  logic [7:0]     hn;
  logic [IW-1:0]  slot;
  logic           s;
  logic           ok_code;
  logic           exe;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] st);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) r[8*b +: 8] = n[8*b +: 8];
    end
    return r;
  endfunction

  function automatic logic acc_ok(input rapg_ac_type c, input logic dis, input logic [1:0] v);
    case (c)
      AC_ALW:   return 1'b1;
      // a blocked first code grants nothing, even when disabled
      AC_CODE1: return (dis && q.cnt[0] != 2'h0) || v[0];
      AC_CODE2: return v[1];
      default:  return 1'b0;
    endcase
  endfunction

  // returns {valid, record number} for the four record modes
  function automatic logic [8:0] step(input logic [1:0] m, input logic cyc, input logic def,
                                      input logic [7:0] p, input logic [7:0] num);
    logic       ok;
    logic [7:0] n;
    ok = 1'b1;
    n  = p;
    case (m)
      2'h0: ok = def;
      2'h1: begin
        n  = num;
        ok = (num != 8'h00) && (num <= LAST);
      end
      2'h2: begin
        if (!def) begin
          n = 8'h01;
        end else if (p == LAST) begin
          n  = 8'h01;
          ok = cyc;
        end else begin
          n = p + 8'h01;
        end
      end
      default: begin
        if (!def) begin
          n = LAST;
        end else if (p == 8'h01) begin
          n  = LAST;
          ok = cyc;
        end else begin
          n = p - 8'h01;
        end
      end
    endcase
    return {ok, n};
  endfunction

  // cyclic record one lives at the head slot
  function automatic logic [IW-1:0] phys(input logic cyc, input logic [IW-1:0] h, input logic [7:0] n);
    logic [7:0] i;
    i = n - 8'h01;
    return cyc ? IW'(i) + h : IW'(i);
  endfunction

  function automatic logic match(input logic [127:0] r, input logic [127:0] p, input logic [4:0] len);
    logic m;
    m = 1'b1;
    for (int b = 0; b < 16; b++) begin
      if (5'(b) < len && r[8*b +: 8] != p[8*b +: 8]) m = 1'b0;
    end
    return m;
  endfunction

  assign kind     = rapg_kind_type'(q.cfg[1:0]);
  assign rdc      = rapg_ac_type'(q.cfg[`RAPG_CFG_RDC +: 2]);
  assign upc      = rapg_ac_type'(q.cfg[`RAPG_CFG_UPC +: 2]);
  assign plen     = q.arg[`RAPG_ARG_PLEN +: 5];
  assign rec_file = (kind == K_LINEAR) || (kind == K_CYCLIC);
  assign exe      = (q.fsm == FSM_EXEC);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d       = q;
    sr      = step(q.mode, kind == K_CYCLIC, q.pdef, q.ptr, q.arg[7:0]);
    slot    = q.head - IW'(1);
    s       = q.sel;
    ok_code = (q.din[0] == q.code[s]);
    case (q.mode)
      2'h0:    sstart = 8'h01;
      2'h1:    sstart = LAST;
      2'h2:    sstart = q.pdef ? q.ptr + 8'h01 : 8'h01;
      default: sstart = q.pdef ? q.ptr - 8'h01 : LAST;
    endcase
    hn = 8'h00;
    for (int i = 1; i <= NREC; i++) begin
      if (match(q.mem[i-1], q.din, plen) &&
          (q.mode[0] ? 8'(i) <= sstart : (8'(i) >= sstart && hn == 8'h00))) begin
        hn = 8'(i);
      end
    end

    if (awvalid_i && q.awrdy) begin
      d.awrdy  = 1'b0;
      d.awaddr = awaddr_i;
    end
    if (wvalid_i && q.wrdy) begin
      d.wrdy  = 1'b0;
      d.wdata = wdata_i;
      d.wstrb = wstrb_i;
    end
    if (!q.awrdy && !q.wrdy && !q.bvalid) begin
      d.bvalid = 1'b1;
      d.bresp  = `RAPG_RESP_OKAY;
      if (q.awaddr[1:0] != 2'h0) begin
        d.bresp = `RAPG_RESP_SLVERR;
      end else if (q.awaddr[7:4] == `RAPG_PAGE_DIN) begin
        d.din[q.awaddr[3:2]] = wmerge(q.din[q.awaddr[3:2]], q.wdata, q.wstrb);
      end else begin
        case (q.awaddr)
          `RAPG_OFF_CMD: begin
            // a command written while busy is dropped
            if (q.fsm == FSM_IDLE && q.wstrb[0]) begin
              d.op    = rapg_op_type'(q.wdata[3:0]);
              d.mode  = q.wdata[`RAPG_CMD_MODE +: 2];
              d.type2 = q.wdata[`RAPG_CMD_TYPE2];
              d.sel   = q.wdata[`RAPG_CMD_SEL];
              d.fsm   = FSM_EXEC;
            end
          end
          `RAPG_OFF_ARG:  d.arg  = wmerge(q.arg, q.wdata, q.wstrb) & `RAPG_ARG_MASK;
          `RAPG_OFF_CFG:  d.cfg  = wmerge(q.cfg, q.wdata, q.wstrb) & `RAPG_CFG_MASK;
          `RAPG_OFF_SKEY: d.skey = wmerge(q.skey, q.wdata, q.wstrb);
          default:        d.bresp = `RAPG_RESP_SLVERR;
        endcase
      end
    end
    if (q.bvalid && bready_i) begin
      d.bvalid = 1'b0;
      d.awrdy  = 1'b1;
      d.wrdy   = 1'b1;
    end

    if (arvalid_i && q.arrdy) begin
      d.arrdy  = 1'b0;
      d.rvalid = 1'b1;
      d.rresp  = `RAPG_RESP_OKAY;
      d.rdata  = 32'h0000_0000;
      if (araddr_i[1:0] != 2'h0) begin
        d.rresp = `RAPG_RESP_SLVERR;
      end else if (araddr_i[7:4] == `RAPG_PAGE_DIN) begin
        d.rdata = q.din[araddr_i[3:2]];
      end else if (araddr_i[7:4] == `RAPG_PAGE_RES) begin
        d.rdata = q.res[araddr_i[3:2]];
      end else begin
        case (araddr_i)
          `RAPG_OFF_CMD:  d.rdata = {24'h00_0000, q.sel, q.type2, q.mode, q.op};
          `RAPG_OFF_ARG:  d.rdata = q.arg;
          `RAPG_OFF_CFG:  d.rdata = q.cfg;
          `RAPG_OFF_STAT: d.rdata = {q.found, q.ptr, 3'h0, q.cnt[1], q.cnt[0], q.ver, q.dis1,
                                     q.pdef, exe, q.status};
          `RAPG_OFF_SKEY: d.rdata = q.skey;
          `RAPG_OFF_CNT:  d.rdata = {24'h00_0000, q.ucnt[1], q.ucnt[0]};
          default:        d.rresp = `RAPG_RESP_SLVERR;
        endcase
      end
    end
    if (q.rvalid && rready_i) begin
      d.rvalid = 1'b0;
      d.arrdy  = 1'b1;
    end

    if (exe) begin
      d.fsm    = FSM_IDLE;
      d.status = S_OK;
      case (q.op)
        OP_SELECT: begin
          d.pdef = (kind == K_CYCLIC);
          d.ptr  = 8'h01;
        end
        OP_READ: begin
          if (!rec_file) begin
            d.status = S_BAD_FILE;
          end else if (!acc_ok(rdc, q.dis1, q.ver)) begin
            d.status = S_ACCESS;
          end else if (!sr[8]) begin
            d.status = S_NO_DATA;
          end else begin
            d.res = q.mem[phys(kind == K_CYCLIC, q.head, sr[7:0])];
            if (q.mode[1]) begin
              d.ptr  = sr[7:0];
              d.pdef = 1'b1;
            end
          end
        end
        OP_UPDATE: begin
          if (!rec_file) begin
            d.status = S_BAD_FILE;
          end else if (!acc_ok(upc, q.dis1, q.ver)) begin
            d.status = S_ACCESS;
          end else if (kind == K_CYCLIC) begin
            if (q.mode != 2'h3) begin
              d.status = S_BAD_MODE;
            end else begin
              d.mem[slot] = q.din;
              d.head      = slot;
              d.ptr       = 8'h01;
              d.pdef      = 1'b1;
            end
          end else if (!sr[8]) begin
            d.status = S_NO_DATA;
          end else begin
            d.mem[phys(1'b0, q.head, sr[7:0])] = q.din;
            if (q.mode[1]) begin
              d.ptr  = sr[7:0];
              d.pdef = 1'b1;
            end
          end
        end
        OP_SEEK: begin
          if (kind != K_LINEAR) begin
            d.status = S_BAD_FILE;
          end else if (!acc_ok(rdc, q.dis1, q.ver)) begin
            d.status = S_ACCESS;
          end else if (plen == 5'h00 || plen > `RAPG_PAT_MAX) begin
            d.status = S_BAD_ARG;
          end else if (hn == 8'h00) begin
            d.status = S_NOT_FOUND;
          end else begin
            d.ptr   = hn;
            d.pdef  = 1'b1;
            d.found = q.type2 ? hn : 8'h00;
          end
        end
        OP_READ_KEY: begin
          if (kind != K_KEY) begin
            d.status = S_BAD_FILE;
          end else if (q.mode != 2'h1) begin
            d.status = S_BAD_MODE;
          end else if (!acc_ok(rdc, q.dis1, q.ver)) begin
            d.status = S_ACCESS;
          end else if (!sr[8]) begin
            d.status = S_NO_DATA;
          end else begin
            d.res = q.mem[phys(1'b0, q.head, sr[7:0])] ^ (q.cfg[`RAPG_CFG_SEAL] ? {4{q.skey}} : 128'h0);
          end
        end
        OP_VERIFY, OP_CHANGE, OP_DISABLE, OP_ENABLE: begin
          if ((q.op == OP_DISABLE || q.op == OP_ENABLE) && s) begin
            d.status = S_BAD_ARG;
          end else if (q.op != OP_ENABLE && !s && q.dis1) begin
            d.status = S_STATE;
          end else if (q.op == OP_ENABLE && !q.dis1) begin
            d.status = S_STATE;
          end else if (q.cnt[s] == 2'h0) begin
            d.status = S_BLOCKED;
          end else if (ok_code) begin
            d.cnt[s] = `RAPG_CODE_TRIES;
            d.ver[s] = 1'b1;
            if (q.op == OP_CHANGE) d.code[s] = q.din[1];
            if (q.op == OP_DISABLE) d.dis1 = 1'b1;
            if (q.op == OP_ENABLE) d.dis1 = 1'b0;
          end else begin
            d.status = S_WRONG;
            d.cnt[s] = q.cnt[s] - 2'h1;
            if (q.cnt[s] == 2'h1) d.ver[s] = 1'b0;
          end
        end
        OP_UNBLOCK: begin
          if (q.ucnt[s] == 4'h0) begin
            d.status = S_BLOCKED;
          end else if (q.din[0] == q.ucode[s]) begin
            d.code[s] = q.din[1];
            d.ucnt[s] = `RAPG_UNBLK_TRIES;
            d.cnt[s]  = `RAPG_CODE_TRIES;
            d.ver[s]  = 1'b1;
            if (!s) d.dis1 = 1'b0;
          end else begin
            d.status  = S_WRONG;
            d.ucnt[s] = q.ucnt[s] - 4'h1;
          end
        end
        OP_END_SESSION: d.ver = 2'h0;
        default:        d.status = S_BAD_OP;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q       <= '0;
      q.awrdy <= 1'b1;
      q.wrdy  <= 1'b1;
      q.arrdy <= 1'b1;
      q.code  <= {CODE2_INIT, CODE1_INIT};
      q.ucode <= {UNBLK2_INIT, UNBLK1_INIT};
      q.cnt   <= {2{`RAPG_CODE_TRIES}};
      q.ucnt  <= {2{`RAPG_UNBLK_TRIES}};
    end else begin
      q <= d;
    end
  end

  assign awready_o = q.awrdy;
  assign wready_o  = q.wrdy;
  assign bvalid_o  = q.bvalid;
  assign bresp_o   = q.bresp;
  assign arready_o = q.arrdy;
  assign rvalid_o  = q.rvalid;
  assign rdata_o   = q.rdata;
  assign rresp_o   = q.rresp;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  a_rd_prev_undef: assert property (
    exe && q.op == OP_READ && q.mode == 2'h3 && rec_file && acc_ok(rdc, q.dis1, q.ver) && !q.pdef
    |=> q.pdef && q.ptr == LAST && q.status == S_OK) else $error("previous read did not land on last");
  a_rd_prev_first: assert property (
    exe && q.op == OP_READ && q.mode == 2'h3 && kind == K_LINEAR && acc_ok(rdc, q.dis1, q.ver)
    && q.pdef && q.ptr == 8'h01 |=> q.ptr == 8'h01 && q.status == S_NO_DATA) else $error("linear first moved");
  a_rd_prev_wrap: assert property (
    exe && q.op == OP_READ && q.mode == 2'h3 && kind == K_CYCLIC && acc_ok(rdc, q.dis1, q.ver)
    && q.pdef && q.ptr == 8'h01 |=> q.ptr == LAST && q.status == S_OK) else $error("cyclic wrap failed");
  a_cyc_upd_mode: assert property (
    exe && q.op == OP_UPDATE && kind == K_CYCLIC && acc_ok(upc, q.dis1, q.ver) && q.mode != 2'h3
    |=> q.status == S_BAD_MODE && $stable(q.mem)) else $error("cyclic update mode accepted");
  a_seek_miss_ptr: assert property (
    (exe && q.op == OP_SEEK) ##1 (q.status != S_OK)
    |-> q.ptr == $past(q.ptr) && q.pdef == $past(q.pdef)) else $error("failed search moved pointer");
  a_verify_ok_cnt: assert property (
    exe && q.op == OP_VERIFY && !(q.dis1 && !q.sel) && q.cnt[q.sel] != 2'h0 && ok_code
    |=> q.cnt[q.sel] == 2'h3 && q.ver[q.sel]) else $error("good code did not restore count");
  a_block_no_right: assert property (
    q.cnt[0] == 2'h0 |-> !q.ver[0] && !acc_ok(AC_CODE1, q.dis1, q.ver)) else $error("blocked code grants access");
  a_disable_refuse: assert property (
    exe && q.op == OP_DISABLE && !q.sel && q.dis1
    |=> q.status == S_STATE && q.dis1 && $stable(q.cnt)) else $error("disable accepted when disabled");
  a_unblock_cnt: assert property (
    exe && q.op == OP_UNBLOCK && q.ucnt[q.sel] != 4'h0 && q.din[0] == q.ucode[q.sel]
    |=> q.ucnt[q.sel] == 4'ha && q.cnt[q.sel] == 2'h3) else $error("unblock did not restore counters");
  a_bvalid_hold: assert property (
    q.bvalid && !bready_i |=> q.bvalid && $stable(q.bresp)) else $error("write response dropped");

  c_seek_hit: cover property (exe && q.op == OP_SEEK ##1 q.status == S_OK);
  c_code_block: cover property (q.cnt[0] == 2'h1 ##1 q.cnt[0] == 2'h0);
  c_cyc_update: cover property (exe && q.op == OP_UPDATE && kind == K_CYCLIC ##1 q.status == S_OK);
  c_key_seal: cover property (exe && q.op == OP_READ_KEY && q.cfg[`RAPG_CFG_SEAL] ##1 q.status == S_OK);

endmodule // rapg_top

// ==== verif/rapg_terminal.sv ====
`timescale 1ns/1ps

module rapg_terminal (
  input  wire logic        clk_sys_i,
  output logic             awvalid_o,
  input  wire logic        awready_i,
  output logic [7:0]       awaddr_o,
  output logic             wvalid_o,
  input  wire logic        wready_i,
  output logic [31:0]      wdata_o,
  output logic [3:0]       wstrb_o,
  input  wire logic        bvalid_i,
  output logic             bready_o,
  output logic             arvalid_o,
  input  wire logic        arready_i,
  output logic [7:0]       araddr_o,
  input  wire logic        rvalid_i,
  output logic             rready_o
);
  initial begin
    awvalid_o = 1'b0;
    wvalid_o  = 1'b0;
    bready_o  = 1'b0;
    arvalid_o = 1'b0;
    rready_o  = 1'b0;
    awaddr_o  = 8'h00;
    araddr_o  = 8'h00;
    wdata_o   = 32'h0000_0000;
    wstrb_o   = 4'h0;
  end

  // ----------------------------------------
  // terminal bus cycles
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge clk_sys_i);
    awaddr_o  <= a;
    wdata_o   <= d;
    wstrb_o   <= 4'hf;
    awvalid_o <= 1'b1;
    wvalid_o  <= 1'b1;
    bready_o  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk_sys_i);
      if (awvalid_o && awready_i) begin
        aw_done = 1'b1;
        awvalid_o <= 1'b0;
        awaddr_o  <= ~a;
      end
      if (wvalid_o && wready_i) begin
        w_done = 1'b1;
        wvalid_o <= 1'b0;
        wdata_o  <= ~d;
      end
    end
    while (!bvalid_i) @(posedge clk_sys_i);
    bready_o <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    araddr_o  <= a;
    arvalid_o <= 1'b1;
    rready_o  <= 1'b1;
    do @(posedge clk_sys_i); while (!arready_i);
    arvalid_o <= 1'b0;
    araddr_o  <= ~a;
    while (!rvalid_i) @(posedge clk_sys_i);
    rready_o <= 1'b0;
  endtask
endmodule // rapg_terminal

// ==== verif/test_record_access_and_pin_guard.sv ====
`timescale 1ns/1ps
`include "rapg_defines.svh"

module test_record_access_and_pin_guard import rapg_pkg::*; ;
  logic        clk_sys, arst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, seed;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [33:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [1:0]  bexp_q[$];
  int          miscompares, comparisons;

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  rapg_top dut_u (.clk_sys_i(clk_sys), .arst_n_i(arst_n), .awvalid_i(awvalid), .awready_o(awready),
    .awaddr_i(awaddr), .wvalid_i(wvalid), .wready_o(wready), .wdata_i(wdata), .wstrb_i(wstrb),
    .bvalid_o(bvalid), .bready_i(bready), .bresp_o(bresp), .arvalid_i(arvalid), .arready_o(arready),
    .araddr_i(araddr), .rvalid_o(rvalid), .rready_i(rready), .rdata_o(rdata), .rresp_o(rresp));

  rapg_terminal term_u (.clk_sys_i(clk_sys), .awvalid_o(awvalid), .awready_i(awready), .awaddr_o(awaddr),
    .wvalid_o(wvalid), .wready_i(wready), .wdata_o(wdata), .wstrb_o(wstrb), .bvalid_i(bvalid),
    .bready_o(bready), .arvalid_o(arvalid), .arready_i(arready), .araddr_o(araddr), .rvalid_i(rvalid),
    .rready_o(rready));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input logic [33:0] seen, input logic [33:0] expd);
    comparisons++;
    if (seen !== expd) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expd);
    end
  endtask

  task automatic expect_rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d, input logic [31:0] m);
    exp_q.push_back({r, d & m});
    msk_q.push_back(m);
    term_u.rd(a);
  endtask

  task automatic wr_exp(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bexp_q.push_back(r);
    term_u.wr(a, d);
  endtask

  task automatic cmd(input logic [31:0] c);
    wr_exp(`RAPG_OFF_CMD, c, `RAPG_RESP_OKAY);
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic complete_run();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // read and write response monitor
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (rvalid === 1'b1 && rready === 1'b1 && exp_q.size() > 0) begin
      check({rresp, rdata & msk_q.pop_front()}, exp_q.pop_front());
    end
    if (bvalid === 1'b1 && bready === 1'b1 && bexp_q.size() > 0) begin
      check({32'h0, bresp}, {32'h0, bexp_q.pop_front()});
    end
  end

  initial begin
    #300000;
    miscompares++;
    complete_run();
  end

  initial begin
    arst_n = 1'b0;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    expect_rd(`RAPG_OFF_STAT, `RAPG_RESP_OKAY, 32'h0000_1e00, 32'hffff_ffff);
    expect_rd(`RAPG_OFF_CNT, `RAPG_RESP_OKAY, 32'h0000_00aa, 32'hffff_ffff);
    expect_rd(8'h18, `RAPG_RESP_SLVERR, 32'h0, 32'h0);
    wr_exp(`RAPG_OFF_STAT, 32'h0, `RAPG_RESP_SLVERR);
    $display("test reset and map done");
    seed = lfsr(32'h32c5);
    term_u.wr(8'h20, seed);
    cmd(32'h22);
    expect_rd(`RAPG_OFF_STAT, `RAPG_RESP_OKAY, 32'h0001_0020, 32'h00ff_003f);
    cmd(32'h31);
    expect_rd(`RAPG_OFF_STAT, `RAPG_RESP_OKAY, 32'h0001_0021, 32'h00ff_003f);
    $display("test record pointer done");
    term_u.wr(`RAPG_OFF_ARG, 32'h0000_0100);
    cmd(32'h43);
    expect_rd(`RAPG_OFF_STAT, `RAPG_RESP_OKAY, 32'h0101_0020, 32'hffff_003f);
    term_u.wr(8'h20, ~seed);
    cmd(32'h43);
    expect_rd(`RAPG_OFF_STAT, `RAPG_RESP_OKAY, {24'h0101_00, 4'h2, S_NOT_FOUND}, 32'hffff_003f);
    $display("test search done");
    term_u.wr(8'h20, 32'h0000_1110);
    for (int i = 1; i <= 3; i++) begin
      cmd(32'h05);
      expect_rd(`RAPG_OFF_STAT, `RAPG_RESP_OKAY, ((3 - i) << 9) | S_WRONG, 32'h0000_060f);
    end
    cmd(32'h05);
    expect_rd(`RAPG_OFF_STAT, `RAPG_RESP_OKAY, {28'h0, S_BLOCKED}, 32'h0000_060f);
    $display("test blocking done");
    term_u.wr(8'h20, 32'h0000_3333);
    term_u.wr(8'h24, 32'h0000_5555);
    cmd(32'h09);
    expect_rd(`RAPG_OFF_STAT, `RAPG_RESP_OKAY, 32'h0000_0600, 32'h0000_060f);
    expect_rd(`RAPG_OFF_CNT, `RAPG_RESP_OKAY, 32'h0000_000a, 32'h0000_000f);
    term_u.wr(8'h20, 32'h0000_5555);
    cmd(32'h05);
    expect_rd(`RAPG_OFF_STAT, `RAPG_RESP_OKAY, 32'h0000_0680, 32'h0000_06cf);
    $display("test unblock done");
    term_u.wr(`RAPG_OFF_CFG, 32'h0000_0004);
    cmd(32'h0a);
    cmd(32'h01);
    expect_rd(`RAPG_OFF_STAT, `RAPG_RESP_OKAY, 32'h0001_0022, 32'h00ff_00ff);
    cmd(32'h07);
    cmd(32'h0a);
    cmd(32'h01);
    expect_rd(`RAPG_OFF_STAT, `RAPG_RESP_OKAY, 32'h0001_0060, 32'h00ff_00ff);
    expect_rd(8'h30, `RAPG_RESP_OKAY, seed, 32'hffff_ffff);
    cmd(32'h07);
    expect_rd(`RAPG_OFF_STAT, `RAPG_RESP_OKAY, 32'h0000_0047, 32'h0000_004f);
    term_u.wr(8'h20, 32'h0000_1110);
    cmd(32'h08);
    expect_rd(`RAPG_OFF_STAT, `RAPG_RESP_OKAY, 32'h0000_0445, 32'h0000_064f);
    term_u.wr(8'h20, 32'h0000_5555);
    cmd(32'h08);
    expect_rd(`RAPG_OFF_STAT, `RAPG_RESP_OKAY, 32'h0000_0680, 32'h0000_06cf);
    term_u.wr(8'h24, seed);
    cmd(32'h06);
    term_u.wr(8'h20, seed);
    cmd(32'h05);
    expect_rd(`RAPG_OFF_STAT, `RAPG_RESP_OKAY, 32'h0000_0600, 32'h0000_060f);
    $display("test code states done");
    term_u.wr(`RAPG_OFF_SKEY, 32'h5a5a_0f0f);
    term_u.wr(`RAPG_OFF_CFG, 32'h0000_0042);
    term_u.wr(`RAPG_OFF_ARG, 32'h0000_0101);
    cmd(32'h04);
    expect_rd(`RAPG_OFF_STAT, `RAPG_RESP_OKAY, 32'h0000_0003, 32'h0000_000f);
    cmd(32'h14);
    expect_rd(8'h34, `RAPG_RESP_OKAY, 32'h5a5a_0f0f, 32'hffff_ffff);
    expect_rd(8'h30, `RAPG_RESP_OKAY, seed ^ 32'h5a5a_0f0f, 32'hffff_ffff);
    term_u.wr(`RAPG_OFF_CFG, 32'h0000_0001);
    cmd(32'h00);
    term_u.wr(8'h20, ~seed);
    cmd(32'h22);
    expect_rd(`RAPG_OFF_STAT, `RAPG_RESP_OKAY, 32'h0001_0023, 32'h00ff_003f);
    cmd(32'h32);
    cmd(32'h11);
    expect_rd(8'h30, `RAPG_RESP_OKAY, ~seed, 32'hffff_ffff);
    cmd(32'h31);
    expect_rd(`RAPG_OFF_STAT, `RAPG_RESP_OKAY, 32'h0008_0020, 32'h00ff_003f);
    $display("test key and cyclic done");
    repeat (4) @(posedge clk_sys);
    complete_run();
  end
endmodule // test_record_access_and_pin_guard
